// File: shared/ssioc_defines.vh
// Purpose: Shared constants of the servo sequence I/O control block
// Assumes: 25 MHz system clock, APB register access with 32-bit words
// Notes: Offsets are byte addresses on the APB bus
`ifndef SSIOC_DEFINES_VH
`define SSIOC_DEFINES_VH

// ==========================================================================
// Timing
`define SSIOC_CLK_MHZ 25
`define SSIOC_CLR_MIN_US 20
`define SSIOC_CLR_MIN_CYC (`SSIOC_CLR_MIN_US * `SSIOC_CLK_MHZ)
`define SSIOC_INIT_CYC 16

// ==========================================================================
// Register byte offsets
`define SSIOC_OFS_CTRL 12'h000
`define SSIOC_OFS_WINDOW 12'h004
`define SSIOC_OFS_FORMAT 12'h008
`define SSIOC_OFS_STATUS 12'h00C
`define SSIOC_OFS_ERRCNT 12'h010
`define SSIOC_OFS_IRQ_STAT 12'h014
`define SSIOC_OFS_IRQ_MASK 12'h018
`define SSIOC_OFS_FAULT_SET 12'h01C

// ==========================================================================
// Control fields
`define SSIOC_CTRL_JOG_FWD 0
`define SSIOC_CTRL_JOG_REV 1
`define SSIOC_CTRL_BRAKE_RELEASE 2

// ==========================================================================
// Status fields
`define SSIOC_ST_RUN 0
`define SSIOC_ST_FAULT 1
`define SSIOC_ST_INPOS 2
`define SSIOC_ST_LOOP_EN 3
`define SSIOC_ST_INIT_DONE 4

// ==========================================================================
// Interrupt status fields
`define SSIOC_IRQ_FAULT 0
`define SSIOC_IRQ_CLEAR 1
`define SSIOC_IRQ_INPOS 2
`define SSIOC_IRQ_W 3

// ==========================================================================
// Reset values
`define SSIOC_WINDOW_RST 16'h0007
`define SSIOC_FORMAT_RST 4'h0

`endif

// File: verilog/ssioc_pulse_decoder.v
// Purpose: Command pulse decoder producing signed count steps
// Assumes: Pulse inputs are already synchronised to clock
// Notes: Format 0..4 positive logic, 5..9 the same decoders inverted
`timescale 1ns/10ps
`default_nettype none

module ssioc_pulse_decoder (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Configuration
    input wire [3:0] pulse_input_format,
    // Synchronised pulse pins
    input wire pin_a,
    input wire pin_b,
    // Decoded steps
    output reg step_up,
    output reg step_down
);

    // Previous sampled levels of both pins
    reg a_prev_reg;
    reg b_prev_reg;
    // Logic-corrected levels
    wire neg;
    wire a_now;
    wire b_now;
    reg [2:0] mode;

    assign neg = (pulse_input_format >= 4'h5) && (pulse_input_format <= 4'h9);
    assign a_now = pin_a ^ neg;
    assign b_now = pin_b ^ neg;

    // ==========================================================================
    // Mode inside the logic group
    always @* begin
        if (pulse_input_format <= 4'h4) begin
            mode = pulse_input_format[2:0]; // R12
        end else if (pulse_input_format <= 4'h9) begin
            mode = pulse_input_format[2:0] - 3'h5; // R12
        end else begin
            mode = 3'h7; // Out of range settings decode nothing
        end
    end

    // ==========================================================================
    // Edge decoding, one step per qualifying edge
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            step_up <= 1'b0;
            step_down <= 1'b0;
        end else begin
            a_prev_reg <= a_now;
            b_prev_reg <= b_now;
            step_up <= 1'b0;
            step_down <= 1'b0;
            case (mode)
                3'h0: begin
                    // Feed pulse on A rising, direction on B
                    if (a_now && !a_prev_reg) begin
                        step_up <= b_now;
                        step_down <= !b_now;
                    end
                end
                3'h1: begin
                    // A is reverse pulse, B forward pulse
                    step_down <= a_now && !a_prev_reg;
                    step_up <= b_now && !b_prev_reg;
                end
                3'h2: begin
                    // Quadrature x1: A rising only
                    if (a_now && !a_prev_reg) begin
                        step_up <= !b_now;
                        step_down <= b_now;
                    end
                end
                3'h3: begin
                    // Quadrature x2: both edges of A
                    if (a_now != a_prev_reg) begin
                        step_up <= a_now ^ b_now;
                        step_down <= !(a_now ^ b_now);
                    end
                end
                3'h4: begin
                    // Quadrature x4: every edge of A or B
                    if (a_now != a_prev_reg) begin
                        step_up <= a_now ^ b_now;
                        step_down <= !(a_now ^ b_now);
                    end else if (b_now != b_prev_reg) begin
                        step_up <= !(a_now ^ b_now);
                        step_down <= a_now ^ b_now;
                    end
                end
                default: ; // Both steps stay low from the defaults above
            endcase
        end
    end

endmodule // ssioc_pulse_decoder

`default_nettype wire

// File: verilog/ssioc_top.v
// Purpose: Sequence input/output logic of a pulse-commanded servo drive
// Assumes: 25 MHz clock, APB slave with zero wait states, pins asynchronous
// Notes: Outputs are active high levels; fault output high means healthy
//
// Decided for this implementation: register access over APB and the register addresses.
`include "ssioc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: Clear input zeroes error count, disables loop
// R2: Controller holds clear at least 20 us
// R3: Clear shorter than 20 us is ignored
// R4: Run on enables power stage, off servo-off
// R5: Servo-off refuses motion except jog
// R6: Alarm reset clears the latched fault
// R7: Controller drops run before alarm reset
// R8: Any detected error turns fault output off
// R9: Fault output off until initialisation completes
// R10: In-position on while |error| below window
// R11: Brake-hold output times external holding brake
// R12: Format setting selects pulse decoding and logic
// R13: All sequence inputs pass two-stage synchroniser
module ssioc_top #(
    parameter CNT_W = 16,
    parameter CLR_MIN_CYC = `SSIOC_CLR_MIN_CYC,
    parameter INIT_CYC = `SSIOC_INIT_CYC
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Command pulse pins
    input wire pulse_a_in,
    input wire pulse_b_in,
    // Sequence inputs
    input wire deviation_clear_in,
    input wire run_in,
    input wire alarm_reset_in,
    // Error sources from the drive
    input wire drive_error_in,
    // Sequence outputs
    output reg fault_indicator_out,
    output reg in_position_out,
    output reg brake_hold_out,
    output reg power_stage_on,
    output reg loop_enable_out,
    // Interrupt
    output wire irq
);

    // ==========================================================================
    // Declarations
    // Synchroniser stages: first stage is read only by the second
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;
    wire pa_s;
    wire pb_s;
    wire clr_s;
    wire run_s;
    wire arst_s;
    wire err_s;
    // Clear width qualification
    reg [15:0] clr_cnt_reg;
    reg clr_ok_reg;
    // Error counter, signed
    reg signed [CNT_W-1:0] err_cnt_reg;
    wire step_up;
    wire step_down;
    wire move_up;
    wire move_down;
    // Fault and init state
    reg [7:0] init_cnt_reg;
    reg init_done_reg;
    reg fault_reg;
    reg fault_sw_reg;
    // Configuration registers
    reg [2:0] ctrl_reg;
    reg [15:0] window_reg;
    reg [3:0] format_reg;
    reg [`SSIOC_IRQ_W-1:0] irq_stat_reg;
    reg [`SSIOC_IRQ_W-1:0] irq_mask_reg;
    reg [`SSIOC_IRQ_W-1:0] irq_ev;
    reg inpos_prev_reg;
    wire wr_en;
    wire rd_en;
    wire inpos_now;

    // Magnitude of the signed error count
    function [CNT_W-1:0] abs_val;
        input [CNT_W-1:0] v;
        begin
            abs_val = v[CNT_W-1] ? (~v + {{(CNT_W-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    // ==========================================================================
    // Input synchronisers
    // Every pin passes two flops before use, including width counting
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= {drive_error_in, alarm_reset_in, run_in, deviation_clear_in, pulse_b_in, pulse_a_in}; // R13
            sync2_reg <= sync1_reg; // R13
        end
    end

    assign pa_s = sync2_reg[0];
    assign pb_s = sync2_reg[1];
    assign clr_s = sync2_reg[2];
    assign run_s = sync2_reg[3];
    assign arst_s = sync2_reg[4];
    assign err_s = sync2_reg[5];

    // ==========================================================================
    // Pulse decoder
    ssioc_pulse_decoder u_dec (
        .clock(clock),
        .sys_rst(sys_rst),
        .pulse_input_format(format_reg),
        .pin_a(pa_s),
        .pin_b(pb_s),
        .step_up(step_up),
        .step_down(step_down)
    );

    // ==========================================================================
    // Deviation clear qualification
    // Clear only acts once the input has stood for the minimum width;
    // shorter glitches leave the count untouched
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clr_cnt_reg <= 16'h0000;
            clr_ok_reg <= 1'b0;
        end else if (!clr_s) begin
            clr_cnt_reg <= 16'h0000; // R3
            clr_ok_reg <= 1'b0;
        end else if (clr_cnt_reg < CLR_MIN_CYC[15:0] - 16'h0001) begin
            clr_cnt_reg <= clr_cnt_reg + 16'h0001; // R3
        end else begin
            clr_ok_reg <= 1'b1; // R3
        end
    end

    // ==========================================================================
    // Motion gating
    // Servo-off passes only jog steps; a qualified clear blocks everything
    assign move_up = !clr_ok_reg && step_up && (power_stage_on || ctrl_reg[`SSIOC_CTRL_JOG_FWD]); // R5
    assign move_down = !clr_ok_reg && step_down && (power_stage_on || ctrl_reg[`SSIOC_CTRL_JOG_REV]); // R5

    // ==========================================================================
    // Error counter
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            err_cnt_reg <= {CNT_W{1'b0}};
        end else if (clr_ok_reg) begin
            err_cnt_reg <= {CNT_W{1'b0}}; // R1
        end else if (move_up && !move_down) begin
            err_cnt_reg <= err_cnt_reg + 1'b1;
        end else if (move_down && !move_up) begin
            err_cnt_reg <= err_cnt_reg - 1'b1;
        end
    end

    // ==========================================================================
    // Initialisation and fault latch
    // Alarm reset while run is on is ignored, as the hazard demands
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            init_cnt_reg <= 8'h00;
            init_done_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            if (!init_done_reg) begin
                if (init_cnt_reg == INIT_CYC[7:0] - 8'h01) begin
                    init_done_reg <= 1'b1; // R9
                end else begin
                    init_cnt_reg <= init_cnt_reg + 8'h01;
                end
            end
            if (err_s || fault_sw_reg) begin
                fault_reg <= 1'b1; // R8
            end else if (arst_s && !run_s) begin
                fault_reg <= 1'b0; // R6 R7
            end
        end
    end

    // ==========================================================================
    // Sequence outputs
    assign inpos_now = abs_val(err_cnt_reg) < window_reg[CNT_W-1:0];

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fault_indicator_out <= 1'b0;
            in_position_out <= 1'b0;
            brake_hold_out <= 1'b0;
            power_stage_on <= 1'b0;
            loop_enable_out <= 1'b0;
        end else begin
            fault_indicator_out <= init_done_reg && !fault_reg && !err_s; // R8 R9
            in_position_out <= inpos_now; // R10
            power_stage_on <= run_s && init_done_reg && !fault_reg; // R4
            loop_enable_out <= run_s && init_done_reg && !fault_reg && !clr_ok_reg; // R1
            // Brake released only while powered, or forced by software
            brake_hold_out <= (run_s && init_done_reg && !fault_reg) || ctrl_reg[`SSIOC_CTRL_BRAKE_RELEASE]; // R11
        end
    end

    // ==========================================================================
    // APB slave
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Interrupt events
    always @* begin
        irq_ev = {`SSIOC_IRQ_W{1'b0}};
        irq_ev[`SSIOC_IRQ_FAULT] = err_s && !fault_reg;
        irq_ev[`SSIOC_IRQ_CLEAR] = clr_s && !clr_ok_reg && (clr_cnt_reg == CLR_MIN_CYC[15:0] - 16'h0001);
        irq_ev[`SSIOC_IRQ_INPOS] = inpos_now && !inpos_prev_reg;
    end

    // Register writes; a fresh event beats a write-one clear
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= 3'h0;
            window_reg <= `SSIOC_WINDOW_RST;
            format_reg <= `SSIOC_FORMAT_RST;
            irq_stat_reg <= {`SSIOC_IRQ_W{1'b0}};
            irq_mask_reg <= {`SSIOC_IRQ_W{1'b0}};
            inpos_prev_reg <= 1'b0;
            fault_sw_reg <= 1'b0;
        end else begin
            inpos_prev_reg <= inpos_now;
            fault_sw_reg <= 1'b0;
            if (wr_en && paddr == `SSIOC_OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[`SSIOC_IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            if (wr_en) begin
                if (paddr == `SSIOC_OFS_CTRL) begin
                    ctrl_reg <= pwdata[2:0];
                end else if (paddr == `SSIOC_OFS_WINDOW) begin
                    window_reg <= pwdata[15:0];
                end else if (paddr == `SSIOC_OFS_FORMAT) begin
                    format_reg <= pwdata[3:0]; // R12
                end else if (paddr == `SSIOC_OFS_IRQ_MASK) begin
                    irq_mask_reg <= pwdata[`SSIOC_IRQ_W-1:0];
                end else if (paddr == `SSIOC_OFS_FAULT_SET) begin
                    fault_sw_reg <= pwdata[0];
                end
            end
        end
    end

    // Read data registered in the setup cycle, valid in the access cycle
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            if (paddr == `SSIOC_OFS_CTRL) begin
                prdata <= {29'h00000000, ctrl_reg};
            end else if (paddr == `SSIOC_OFS_WINDOW) begin
                prdata <= {16'h0000, window_reg};
            end else if (paddr == `SSIOC_OFS_FORMAT) begin
                prdata <= {28'h0000000, format_reg};
            end else if (paddr == `SSIOC_OFS_STATUS) begin
                prdata <= {27'h0000000, init_done_reg, loop_enable_out, in_position_out,
                           fault_reg, power_stage_on};
            end else if (paddr == `SSIOC_OFS_ERRCNT) begin
                prdata <= {{(32-CNT_W){err_cnt_reg[CNT_W-1]}}, err_cnt_reg};
            end else if (paddr == `SSIOC_OFS_IRQ_STAT) begin
                prdata <= {29'h00000000, irq_stat_reg};
            end else if (paddr == `SSIOC_OFS_IRQ_MASK) begin
                prdata <= {29'h00000000, irq_mask_reg};
            end else begin
                prdata <= 32'h00000000; // Unmapped reads as zero
            end
        end
    end

    // Level interrupt while any unmasked status bit stands
    assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // ssioc_top

`default_nettype wire

// File: tb/ssioc_chk_sva.sv
// Purpose: Assertions on the sequence pins of the servo I/O block
// Assumes: One clock, asynchronous active-high reset
// Notes: Windows allow two sync stages plus one register
`timescale 1ns/10ps
`default_nettype none
// ====================
// Checker
module ssioc_chk #(
    parameter int CLR_MIN_CYC = 8,
    parameter int INIT_CYC = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Sequence inputs
    input wire logic deviation_clear_in,
    input wire logic run_in,
    input wire logic alarm_reset_in,
    input wire logic drive_error_in,
    // Sequence outputs
    input wire logic fault_indicator_out,
    input wire logic in_position_out,
    input wire logic brake_hold_out,
    input wire logic power_stage_on,
    input wire logic loop_enable_out,
    input wire logic irq
);
    int clr_cnt; // Cycles the clear pin has stayed high
    int up_cnt; // Cycles since reset release
    // Saturating counters, so long runs never wrap
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clr_cnt <= 0;
            up_cnt <= 0;
        end else begin
            clr_cnt <= deviation_clear_in ? (clr_cnt < 9999 ? clr_cnt + 1 : clr_cnt) : 0;
            up_cnt <= (up_cnt < 9999) ? up_cnt + 1 : up_cnt;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_clear_off; clr_cnt >= CLR_MIN_CYC + 6 |-> !loop_enable_out; endproperty
    a_clear_off: assert property (p_clear_off) else $error("loop on during clear");
    property p_short_clr;
        $fell(loop_enable_out) && $past(power_stage_on) && power_stage_on && fault_indicator_out
            |-> clr_cnt >= CLR_MIN_CYC;
    endproperty
    a_short_clr: assert property (p_short_clr) else $error("loop dropped by short clear");
    property p_run_off; !run_in [*4] |=> !power_stage_on; endproperty
    a_run_off: assert property (p_run_off) else $error("power on without run");
    property p_run_on; (run_in && fault_indicator_out) [*5] |-> power_stage_on; endproperty
    a_run_on: assert property (p_run_on) else $error("power off with run");
    property p_alarm;
        (alarm_reset_in && !run_in && !drive_error_in && up_cnt > INIT_CYC + 4) [*6] |=> fault_indicator_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm reset not taken");
    property p_err; drive_error_in [*4] |=> !fault_indicator_out; endproperty
    a_err: assert property (p_err) else $error("fault output on during error");
    property p_init; up_cnt < INIT_CYC |-> !fault_indicator_out; endproperty
    a_init: assert property (p_init) else $error("fault output on before init");
    property p_inpos; clr_cnt >= CLR_MIN_CYC + 8 |-> in_position_out; endproperty
    a_inpos: assert property (p_inpos) else $error("in position off at zero count");
    property p_brake; power_stage_on [*2] |-> brake_hold_out; endproperty
    a_brake: assert property (p_brake) else $error("brake held while powered");
    c_clear: cover property (clr_cnt == CLR_MIN_CYC + 6);
    c_irq: cover property ($rose(irq));
    c_alarm: cover property ($rose(fault_indicator_out) && up_cnt > INIT_CYC + 4);
endmodule // ssioc_chk
bind ssioc_top ssioc_chk #(.CLR_MIN_CYC(CLR_MIN_CYC), .INIT_CYC(INIT_CYC)) u_chk (.*);
`default_nettype wire

// File: tb/ssioc_ctrl_model.sv
// Purpose: Position controller model on the pulse and sequence pins
// Assumes: Tasks are entered just after a rising clock edge
// Notes: Negative logic inverts both pulse pins, idle too
`timescale 1ns/10ps
`default_nettype none
// ====================
// Controller model
module ssioc_ctrl_model (
    // Clock
    input wire logic clock,
    // Pulse pins
    output var logic pulse_a_in,
    output var logic pulse_b_in,
    // Sequence pins
    output var logic deviation_clear_in,
    output var logic run_in,
    output var logic alarm_reset_in
);
    logic inv = 1'b0; // High for negative logic formats
    // Idle levels from time zero
    initial begin
        pulse_a_in = 1'b0;
        pulse_b_in = 1'b0;
        deviation_clear_in = 1'b0;
        run_in = 1'b0;
        alarm_reset_in = 1'b0;
    end
    // Three cycles per level keeps edges well apart after sync
    task automatic drive(input logic a, input logic b);
        pulse_a_in <= a ^ inv;
        pulse_b_in <= b ^ inv;
        repeat (3) @(posedge clock);
    endtask
    task automatic set_format(input int f);
        inv = (f >= 5);
        drive(1'b0, 1'b0);
    endtask
    // Quadrature sends whole cycles; A leading B counts up
    task automatic pulses(input int f, input int n, input logic up);
        repeat (n) begin
            if (f % 5 == 0) begin
                drive(1'b0, up);
                drive(1'b1, up);
                drive(1'b0, up);
            end else if (f % 5 == 1) begin
                drive(!up, up);
                drive(1'b0, 1'b0);
            end else begin
                drive(up, !up);
                drive(1'b1, 1'b1);
                drive(!up, up);
                drive(1'b0, 1'b0);
            end
        end
    endtask
    // Short widths are sent only when a test wants a refusal
    task automatic clear(input int cyc);
        deviation_clear_in <= 1'b1;
        repeat (cyc) @(posedge clock);
        deviation_clear_in <= 1'b0;
        @(posedge clock);
    endtask
    task automatic set_run(input logic v);
        run_in <= v;
        @(posedge clock);
    endtask
    // Run is dropped first unless a hazard is asked for
    task automatic alarm(input logic hazard);
        if (!hazard) begin
            run_in <= 1'b0;
            repeat (3) @(posedge clock);
        end
        alarm_reset_in <= 1'b1;
        repeat (8) @(posedge clock);
        alarm_reset_in <= 1'b0;
        @(posedge clock);
    endtask
endmodule // ssioc_ctrl_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the servo sequence I/O block
// Assumes: 25 MHz clock, zero-wait APB, shortened clear qualification
// Notes: An integer model of the error count predicts the readback after each format burst and the short clear
`include "ssioc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
// ====================
// Bench
module tb_top;
    localparam int CLR = 8; // Shortened clear qualification
    localparam int INIT = 16; // Initialisation cycles
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, drive_error_in;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rng = 32'hE56A; // Xorshift state
    logic pready, pslverr, pulse_a_in, pulse_b_in, deviation_clear_in, run_in, alarm_reset_in;
    logic fault_indicator_out, in_position_out, brake_hold_out, power_stage_on, loop_enable_out, irq;
    int failures = 0;
    int total_checks = 0;
    int exp_cnt = 0; // Predicted signed error count
    // 40 ns clock
    initial begin
        forever #20 clock = ~clock;
    end
    ssioc_top #(.CLR_MIN_CYC(CLR), .INIT_CYC(INIT)) u_dut (
        .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pulse_a_in, .pulse_b_in, .deviation_clear_in, .run_in, .alarm_reset_in, .drive_error_in,
        .fault_indicator_out, .in_position_out, .brake_hold_out, .power_stage_on, .loop_enable_out, .irq);
    ssioc_ctrl_model u_ctrl (
        .clock, .pulse_a_in, .pulse_b_in, .deviation_clear_in, .run_in, .alarm_reset_in);
    function logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Setup, then access held until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK(q & m, e)
    endtask
    task automatic done(input string s);
        $display("test %s over, %0d checks so far", s, total_checks);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One format: long clear, random burst, count and window flag
    task automatic fmt_case(input int f);
        int n;
        int up;
        int w;
        n = 1 + rnd() % 4;
        up = rnd() % 2;
        w = 1 + rnd() % 8;
        wr(`SSIOC_OFS_FORMAT, 32'(f));
        wr(`SSIOC_OFS_WINDOW, 32'(w));
        u_ctrl.set_format(f);
        fork
            u_ctrl.clear(2 * CLR);
            begin ticks(2 * CLR); `CHK(loop_enable_out, 1'b0) end
        join
        ticks(8);
        rd(`SSIOC_OFS_ERRCNT, 32'hFFFFFFFF, 32'h0);
        u_ctrl.pulses(f, n, up[0]);
        exp_cnt = (up[0] ? n : -n) * ((f % 5 == 3) ? 2 : (f % 5 == 4) ? 4 : 1);
        ticks(8);
        rd(`SSIOC_OFS_ERRCNT, 32'hFFFFFFFF, 32'(exp_cnt));
        `CHK(in_position_out, 1'(exp_cnt < w && -exp_cnt < w))
    endtask
    // Main sequence
    initial begin
        {psel, penable, pwrite, drive_error_in} <= 4'h0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        ticks(16);
        `CHK(fault_indicator_out, 1'b0)
        sys_rst <= 1'b0;
        ticks(INIT - 2);
        `CHK(fault_indicator_out, 1'b0)
        ticks(8);
        `CHK(fault_indicator_out, 1'b1)
        rd(`SSIOC_OFS_CTRL, 32'h7, 32'h0);
        rd(`SSIOC_OFS_WINDOW, 32'hFFFF, 32'h7);
        rd(`SSIOC_OFS_FORMAT, 32'hF, 32'h0);
        rd(`SSIOC_OFS_IRQ_MASK, 32'h7, 32'h0);
        rd(12'h0F0, 32'hFFFFFFFF, 32'h0);
        done("init");
        drive_error_in <= 1'b1;
        ticks(6);
        `CHK(fault_indicator_out, 1'b0)
        `CHK(irq, 1'b0)
        drive_error_in <= 1'b0;
        rd(`SSIOC_OFS_IRQ_STAT, 32'h1, 32'h1);
        wr(`SSIOC_OFS_IRQ_MASK, 32'h1);
        `CHK(irq, 1'b1)
        u_ctrl.set_run(1'b1);
        u_ctrl.alarm(1'b1);
        `CHK(fault_indicator_out, 1'b0)
        u_ctrl.alarm(1'b0);
        ticks(4);
        `CHK(fault_indicator_out, 1'b1)
        wr(`SSIOC_OFS_IRQ_STAT, 32'h7);
        `CHK(irq, 1'b0)
        wr(`SSIOC_OFS_FAULT_SET, 32'h1);
        ticks(3);
        `CHK(fault_indicator_out, 1'b0)
        u_ctrl.alarm(1'b0);
        ticks(4);
        `CHK(fault_indicator_out, 1'b1)
        done("fault");
        u_ctrl.set_run(1'b1);
        ticks(5);
        `CHK(power_stage_on, 1'b1)
        `CHK(brake_hold_out, 1'b1)
        rd(`SSIOC_OFS_STATUS, 32'h1, 32'h1);
        for (int f = 0; f < 10; f++) fmt_case(f);
        done("formats");
        u_ctrl.clear(CLR - 3);
        ticks(8);
        rd(`SSIOC_OFS_ERRCNT, 32'hFFFFFFFF, 32'(exp_cnt));
        `CHK(loop_enable_out, 1'b1)
        done("short clear");
        u_ctrl.set_run(1'b0);
        ticks(5);
        `CHK(power_stage_on, 1'b0)
        wr(`SSIOC_OFS_FORMAT, 32'h0);
        u_ctrl.set_format(0);
        u_ctrl.clear(2 * CLR);
        ticks(8);
        u_ctrl.pulses(0, 2, 1'b1);
        wr(`SSIOC_OFS_CTRL, 32'h1);
        u_ctrl.pulses(0, 3, 1'b1);
        u_ctrl.pulses(0, 2, 1'b0);
        ticks(8);
        rd(`SSIOC_OFS_ERRCNT, 32'hFFFFFFFF, 32'h3);
        done("jog");
        print_verdict();
    end
    // Watchdog far above the roughly one thousand cycles the tests take
    initial begin
        ticks(20000);
        failures++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
